//--- core/crv_defines.vh
// Constants for the core rail voltage register bank
`ifndef CRV_DEFINES_VH
`define CRV_DEFINES_VH

// ==========================================================================
// Register offsets
`define CRV_OFS_CTL        8'h24
`define CRV_OFS_OP         8'h25
`define CRV_OFS_SR         8'h26
`define CRV_OFS_XCTL       8'h27
`define CRV_OFS_XOP        8'h28
`define CRV_OFS_XSR        8'h29

// ==========================================================================
// Field positions
`define CRV_GAIN_HI        7
`define CRV_GAIN_LO        6
`define CRV_CEIL_BIT       5
`define CRV_RAMP_HI        4
`define CRV_RAMP_LO        2
`define CRV_STATE_HI       1
`define CRV_STATE_LO       0
`define CRV_STATE_ON_BIT   0
`define CRV_STATE_LP_BIT   1
`define CRV_SRC_BIT        7
`define CRV_CODE_HI        6
`define CRV_CODE_LO        0

// ==========================================================================
// Writable masks and reset values
`define CRV_CTL_WMASK      8'hff
`define CRV_OP_WMASK       8'hff
`define CRV_SR_WMASK       8'h7f
`define CRV_XCTL_WMASK     8'h03
`define CRV_XOP_WMASK      8'hff
`define CRV_XSR_WMASK      8'h7f
`define CRV_CTL_RST        8'h0c
`define CRV_OP_RST         8'h00
`define CRV_SR_RST         8'h00
`define CRV_XCTL_RST       8'h00
`define CRV_XOP_RST        8'h00
`define CRV_XSR_RST        8'h03
`define CRV_ZERO8          8'h00

// ==========================================================================
// Level and ratio code limits
`define CRV_LVL_OFF        7'h00
`define CRV_LVL_MIN        7'h03
`define CRV_LVL_MAX        7'h4b
`define CRV_LVL_ONE        7'h01
`define CRV_RATIO_MIN      7'h03
`define CRV_RATIO_MAX      7'h43
`define CRV_RATIO_OFS      7'h2d
`define CRV_TGT_OFS        10'h05a
`define CRV_TGT_ZERO       10'h000

// ==========================================================================
// Gain and ramp codes
`define CRV_GAIN_X1        2'b00
`define CRV_GAIN_TBD       2'b01
`define CRV_GAIN_X2        2'b10
`define CRV_GAIN_X3        2'b11
`define CRV_MUL_1          2'h1
`define CRV_MUL_2          2'h2
`define CRV_MUL_3          2'h3
`define CRV_RAMP_BYPASS    3'h0

// ==========================================================================
// Step sampling timing
`define CRV_CLK_HZ         250000000
`define CRV_SAMPLE_HZ      3000000
`define CRV_ACC_W          24

`endif

//--- core/crv_step_tick.v
// Ramp step tick generator, 3 MHz base scaled by the ramp rate code
`timescale 1ns/1ps
`default_nettype none
`include "crv_defines.vh"

module crv_step_tick (
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire [2:0] rate_code_i,
  output reg        tick_o
);

  // ========================================================================
  // Phase increments
  // Fractional accumulator keeps the mean rate exact at the cost of a
  // one-cycle jitter on each tick.
  localparam [63:0] BASE = ((64'h1 << `CRV_ACC_W) * `CRV_SAMPLE_HZ)
                           / `CRV_CLK_HZ;
  localparam [63:0] INC1 = BASE;
  localparam [63:0] INC2 = (BASE * 64'h3) / 64'h4;
  localparam [63:0] INC3 = (BASE * 64'h3) / 64'h5;
  localparam [63:0] INC4 = BASE / 64'h2;
  localparam [63:0] INC5 = BASE / 64'h3;
  localparam [63:0] INC6 = BASE / 64'h4;
  localparam [63:0] INC7 = BASE / 64'h5;

  reg  [`CRV_ACC_W-1:0] inc_d;
  reg  [`CRV_ACC_W-1:0] acc_q;
  wire [`CRV_ACC_W:0]   sum;

  always @* begin
    case (rate_code_i)
      3'h1: inc_d = INC1[`CRV_ACC_W-1:0];
      3'h2: inc_d = INC2[`CRV_ACC_W-1:0];
      3'h3: inc_d = INC3[`CRV_ACC_W-1:0];
      3'h4: inc_d = INC4[`CRV_ACC_W-1:0];
      3'h5: inc_d = INC5[`CRV_ACC_W-1:0];
      3'h6: inc_d = INC6[`CRV_ACC_W-1:0];
      3'h7: inc_d = INC7[`CRV_ACC_W-1:0];
      default: inc_d = {`CRV_ACC_W{1'b0}};
    endcase
  end

  assign sum = {1'b0, acc_q} + {1'b0, inc_d};

  // ========================================================================
  // Accumulator
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_q  <= {`CRV_ACC_W{1'b0}};
      tick_o <= 1'b0;
    end else begin
      acc_q  <= sum[`CRV_ACC_W-1:0];
      tick_o <= sum[`CRV_ACC_W];
    end
  end

endmodule
`default_nettype wire

//--- core/crv_rail_regs.v
// Second core rail and outboard converter register bank with ramp control
//
// Summary of operation
// - Source bit of operating level picks operating code (0) or scaling code.
// - Source bit of operating ratio picks operating (0) or scaling ratio.
// - Codes 3..75 give target (code x 12.5 mV + 0.5625 V) times gain.
// - Codes 75..127 saturate at 1.5 V, 1..3 give 0.6 V, 0 turns off.
// - Gain field 00 gives x1, 10 gives x2, 11 gives x3.
// - Current ceiling bit 0 selects 1.2 A, 1 selects above 1.7 A.
// - Level changes between codes 3..75 walk in 12.5 mV steps; ramp code 000 jumps at once.
// - Ramp codes 001..111 step at 3 MHz x 1, 3/4, 3/5, 1/2, 1/3, 1/4, 1/5.
// - Ramp code resets to 011, the default slew rate.
// - Rail state 00 or 10 off, 01 on high power, 11 on low power.
// - Outboard state 00 or 10 keeps converter off, 01 or 11 turns on.
// - Paired registers answer only on the port chosen by the port choice.
// - Ratio codes 3..67 give divider ratio 48 over 45 plus code.
// - Ratio codes 67..127 hold 3/7, codes 1..3 give unity.
// - Ratio code zero drives the outboard enable low.
// - Turn-off reset returns every register to its reset value.
`timescale 1ns/1ps
`default_nettype none
`include "crv_defines.vh"

module crv_rail_regs (
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire       scaling_port_choice_i,
  input  wire [7:0] ctl_addr_i,
  input  wire [7:0] ctl_wdata_i,
  input  wire       ctl_wr_i,
  input  wire       ctl_rd_i,
  output reg  [7:0] ctl_rdata_o,
  output reg        ctl_rvalid_o,
  input  wire [7:0] scl_addr_i,
  input  wire [7:0] scl_wdata_i,
  input  wire       scl_wr_i,
  input  wire       scl_rd_i,
  output reg  [7:0] scl_rdata_o,
  output reg        scl_rvalid_o,
  output reg        rail_on_o,
  output reg        rail_low_power_o,
  output reg  [6:0] rail_level_o,
  output reg  [9:0] rail_target_o,
  output reg  [1:0] rail_gain_o,
  output reg        current_ceiling_o,
  output reg        ramp_busy_o,
  output reg        outboard_enable_o,
  output reg  [6:0] outboard_ratio_den_o
);

  // ========================================================================
  // Register storage
  reg  [7:0] ctl_q;
  reg  [7:0] op_q;
  reg  [7:0] sr_q;
  reg  [7:0] xctl_q;
  reg  [7:0] xop_q;
  reg  [7:0] xsr_q;

  // ========================================================================
  // Port ownership
  wire ctl_paired;
  wire scl_paired;
  wire ctl_owns_paired;
  wire scl_owns_paired;

  assign ctl_paired = (ctl_addr_i == `CRV_OFS_OP) ||
                      (ctl_addr_i == `CRV_OFS_SR) ||
                      (ctl_addr_i == `CRV_OFS_XOP) ||
                      (ctl_addr_i == `CRV_OFS_XSR);
  assign scl_paired = (scl_addr_i == `CRV_OFS_OP) ||
                      (scl_addr_i == `CRV_OFS_SR) ||
                      (scl_addr_i == `CRV_OFS_XOP) ||
                      (scl_addr_i == `CRV_OFS_XSR);
  // Only one port ever owns the paired set, so no write collision is possible
  assign ctl_owns_paired = ~scaling_port_choice_i;
  assign scl_owns_paired = scaling_port_choice_i;

  // ========================================================================
  // Write strobes
  wire       we_ctl;
  wire       we_xctl;
  wire       ctl_pw;
  wire       scl_pw;
  wire       we_op;
  wire       we_sr;
  wire       we_xop;
  wire       we_xsr;
  wire [7:0] pw_data;

  assign we_ctl  = ctl_wr_i && (ctl_addr_i == `CRV_OFS_CTL);
  assign we_xctl = ctl_wr_i && (ctl_addr_i == `CRV_OFS_XCTL);
  assign ctl_pw  = ctl_wr_i && ctl_paired && ctl_owns_paired;
  assign scl_pw  = scl_wr_i && scl_paired && scl_owns_paired;
  assign pw_data = scl_owns_paired ? scl_wdata_i : ctl_wdata_i;
  assign we_op   = (ctl_pw && (ctl_addr_i == `CRV_OFS_OP)) ||
                   (scl_pw && (scl_addr_i == `CRV_OFS_OP));
  assign we_sr   = (ctl_pw && (ctl_addr_i == `CRV_OFS_SR)) ||
                   (scl_pw && (scl_addr_i == `CRV_OFS_SR));
  assign we_xop  = (ctl_pw && (ctl_addr_i == `CRV_OFS_XOP)) ||
                   (scl_pw && (scl_addr_i == `CRV_OFS_XOP));
  assign we_xsr  = (ctl_pw && (ctl_addr_i == `CRV_OFS_XSR)) ||
                   (scl_pw && (scl_addr_i == `CRV_OFS_XSR));

  // ========================================================================
  // Register file
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_q  <= `CRV_CTL_RST;
      op_q   <= `CRV_OP_RST;
      sr_q   <= `CRV_SR_RST;
      xctl_q <= `CRV_XCTL_RST;
      xop_q  <= `CRV_XOP_RST;
      xsr_q  <= `CRV_XSR_RST;
    end else begin
      if (we_ctl) begin
        ctl_q <= ctl_wdata_i & `CRV_CTL_WMASK;
      end
      if (we_op) begin
        op_q <= pw_data & `CRV_OP_WMASK;
      end
      if (we_sr) begin
        sr_q <= pw_data & `CRV_SR_WMASK;
      end
      if (we_xctl) begin
        xctl_q <= ctl_wdata_i & `CRV_XCTL_WMASK;
      end
      if (we_xop) begin
        xop_q <= pw_data & `CRV_XOP_WMASK;
      end
      if (we_xsr) begin
        xsr_q <= pw_data & `CRV_XSR_WMASK;
      end
    end
  end

  // ========================================================================
  // Read path
  // Unmapped offsets and paired registers on the idle port read zero
  function [7:0] read_reg;
    input [7:0] addr;
    begin
      case (addr)
        `CRV_OFS_CTL:  read_reg = ctl_q;
        `CRV_OFS_OP:   read_reg = op_q;
        `CRV_OFS_SR:   read_reg = sr_q;
        `CRV_OFS_XCTL: read_reg = xctl_q;
        `CRV_OFS_XOP:  read_reg = xop_q;
        `CRV_OFS_XSR:  read_reg = xsr_q;
        default:       read_reg = `CRV_ZERO8;
      endcase
    end
  endfunction

  wire [7:0] ctl_rd_d;
  wire [7:0] scl_rd_d;

  assign ctl_rd_d = (ctl_paired && !ctl_owns_paired) ? `CRV_ZERO8 :
                    read_reg(ctl_addr_i);
  assign scl_rd_d = (scl_paired && scl_owns_paired) ?
                    read_reg(scl_addr_i) : `CRV_ZERO8;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_rdata_o  <= `CRV_ZERO8;
      ctl_rvalid_o <= 1'b0;
      scl_rdata_o  <= `CRV_ZERO8;
      scl_rvalid_o <= 1'b0;
    end else begin
      ctl_rvalid_o <= ctl_rd_i;
      scl_rvalid_o <= scl_rd_i;
      if (ctl_rd_i) begin
        ctl_rdata_o <= ctl_rd_d;
      end
      if (scl_rd_i) begin
        scl_rdata_o <= scl_rd_d;
      end
    end
  end

  // ========================================================================
  // Field decode
  wire [1:0] gain_field;
  wire [2:0] ramp_code;
  wire [1:0] rail_state;
  wire [6:0] lvl_sel;
  wire [6:0] ratio_sel;

  assign gain_field = ctl_q[`CRV_GAIN_HI:`CRV_GAIN_LO];
  assign ramp_code  = ctl_q[`CRV_RAMP_HI:`CRV_RAMP_LO];
  assign rail_state = ctl_q[`CRV_STATE_HI:`CRV_STATE_LO];
  assign lvl_sel    = op_q[`CRV_SRC_BIT] ?
                      sr_q[`CRV_CODE_HI:`CRV_CODE_LO] :
                      op_q[`CRV_CODE_HI:`CRV_CODE_LO];
  assign ratio_sel  = xop_q[`CRV_SRC_BIT] ?
                      xsr_q[`CRV_CODE_HI:`CRV_CODE_LO] :
                      xop_q[`CRV_CODE_HI:`CRV_CODE_LO];

  // ========================================================================
  // Level clamp and gain
  reg [6:0] lvl_tgt;
  reg [1:0] mul_d;

  always @* begin
    if (lvl_sel == `CRV_LVL_OFF) begin
      lvl_tgt = `CRV_LVL_OFF;
    end else if (lvl_sel < `CRV_LVL_MIN) begin
      lvl_tgt = `CRV_LVL_MIN;
    end else if (lvl_sel > `CRV_LVL_MAX) begin
      lvl_tgt = `CRV_LVL_MAX;
    end else begin
      lvl_tgt = lvl_sel;
    end
  end

  always @* begin
    case (gain_field)
      `CRV_GAIN_X1:  mul_d = `CRV_MUL_1;
      `CRV_GAIN_TBD: mul_d = `CRV_MUL_1;
      `CRV_GAIN_X2:  mul_d = `CRV_MUL_2;
      `CRV_GAIN_X3:  mul_d = `CRV_MUL_3;
      default:       mul_d = `CRV_MUL_1;
    endcase
  end

  // ========================================================================
  // Ramp walker
  wire       step_tick;
  reg  [6:0] lvl_q;
  reg  [6:0] lvl_d;

  crv_step_tick u_tick (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .rate_code_i (ramp_code),
    .tick_o      (step_tick)
  );

  // Codes below the floor carry no voltage, so they are skipped, not walked
  always @* begin
    lvl_d = lvl_q;
    if (ramp_code == `CRV_RAMP_BYPASS) begin
      lvl_d = lvl_tgt;
    end else if (lvl_tgt == `CRV_LVL_OFF) begin
      lvl_d = `CRV_LVL_OFF;
    end else if (lvl_q < `CRV_LVL_MIN) begin
      lvl_d = `CRV_LVL_MIN;
    end else if (step_tick && (lvl_q < lvl_tgt)) begin
      lvl_d = lvl_q + `CRV_LVL_ONE;
    end else if (step_tick && (lvl_q > lvl_tgt)) begin
      lvl_d = lvl_q - `CRV_LVL_ONE;
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lvl_q <= `CRV_LVL_OFF;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  // ========================================================================
  // Rail target in 6.25 mV units: two per code plus 90 for 0.5625 V
  wire [9:0] base_units;
  wire [9:0] tgt_units;
  wire [9:0] tgt_d;

  assign base_units = {2'h0, lvl_d, 1'b0} + `CRV_TGT_OFS;
  assign tgt_units  = (mul_d == `CRV_MUL_3) ?
                      (base_units + {base_units[8:0], 1'b0}) :
                      (mul_d == `CRV_MUL_2) ?
                      {base_units[8:0], 1'b0} : base_units;
  assign tgt_d      = (lvl_d == `CRV_LVL_OFF) ? `CRV_TGT_ZERO : tgt_units;

  // ========================================================================
  // Outboard divider ratio, numerator fixed at 48
  reg  [6:0] ratio_clamp;
  wire [6:0] ratio_den_d;
  wire       xon_d;

  always @* begin
    if (ratio_sel < `CRV_RATIO_MIN) begin
      ratio_clamp = `CRV_RATIO_MIN;
    end else if (ratio_sel > `CRV_RATIO_MAX) begin
      ratio_clamp = `CRV_RATIO_MAX;
    end else begin
      ratio_clamp = ratio_sel;
    end
  end

  assign ratio_den_d = ratio_clamp + `CRV_RATIO_OFS;
  assign xon_d = xctl_q[`CRV_STATE_ON_BIT] &&
                 (ratio_sel != `CRV_LVL_OFF);

  // ========================================================================
  // Output registers
  wire rail_on_d;

  assign rail_on_d = rail_state[`CRV_STATE_ON_BIT] &&
                     (lvl_d != `CRV_LVL_OFF);

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rail_on_o            <= 1'b0;
      rail_low_power_o     <= 1'b0;
      rail_level_o         <= `CRV_LVL_OFF;
      rail_target_o        <= `CRV_TGT_ZERO;
      rail_gain_o          <= `CRV_MUL_1;
      current_ceiling_o    <= 1'b0;
      ramp_busy_o          <= 1'b0;
      outboard_enable_o    <= 1'b0;
      // Same as reset ratio code, so no illegal value before release
      outboard_ratio_den_o <= `CRV_RATIO_MIN + `CRV_RATIO_OFS;
    end else begin
      rail_on_o            <= rail_on_d;
      rail_low_power_o     <= rail_on_d &&
                              rail_state[`CRV_STATE_LP_BIT];
      rail_level_o         <= lvl_d;
      rail_target_o        <= tgt_d;
      rail_gain_o          <= mul_d;
      current_ceiling_o    <= ctl_q[`CRV_CEIL_BIT];
      ramp_busy_o          <= (lvl_d != lvl_tgt);
      outboard_enable_o    <= xon_d;
      outboard_ratio_den_o <= ratio_den_d;
    end
  end

endmodule
`default_nettype wire

//--- sim/crv_rail_props.sv
// Port assertions for the rail register bank
`timescale 1ns/1ps
`default_nettype none
module crv_rail_props (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       ctl_rd_i,
  input wire logic [7:0] ctl_addr_i,
  input wire logic [7:0] ctl_rdata_o,
  input wire logic       ctl_rvalid_o,
  input wire logic       scl_rd_i,
  input wire logic [7:0] scl_addr_i,
  input wire logic [7:0] scl_rdata_o,
  input wire logic       scl_rvalid_o,
  input wire logic       rail_on_o,
  input wire logic       rail_low_power_o,
  input wire logic [6:0] rail_level_o,
  input wire logic [9:0] rail_target_o,
  input wire logic [1:0] rail_gain_o,
  input wire logic       ramp_busy_o,
  input wire logic       outboard_enable_o,
  input wire logic [6:0] outboard_ratio_den_o
);
  logic [9:0] tgt_calc;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  assign tgt_calc = (rail_level_o == 7'h00) ? 10'h000 :
    ({3'h0, rail_level_o} * 10'h002 + 10'h05a) * {8'h00, rail_gain_o};
  // ==========================================================
  // Register ports
  chk_ctl_read_answer: assert property (
    ctl_rvalid_o == $past(ctl_rd_i)) else $error("ctl read answer late");
  chk_scl_read_answer: assert property (
    scl_rvalid_o == $past(scl_rd_i)) else $error("scl read answer late");
  chk_scl_ctl_only: assert property (
    scl_rd_i && (scl_addr_i == 8'h24 || scl_addr_i == 8'h27)
    |=> scl_rdata_o == 8'h00) else $error("scl read of control reg");
  chk_unmapped_zero: assert property (
    ctl_rd_i && ctl_addr_i > 8'h29 |=> ctl_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  // ==========================================================
  // Rail and outboard outputs
  chk_level_range: assert property (
    rail_level_o == 7'h00 || (rail_level_o >= 7'h03 && rail_level_o <= 7'h4b))
    else $error("level out of range");
  chk_on_needs_level: assert property (
    rail_on_o |-> rail_level_o != 7'h00) else $error("rail on at level 0");
  chk_low_power_on: assert property (
    rail_low_power_o |-> rail_on_o) else $error("low power while off");
  chk_gain_legal: assert property (
    rail_gain_o != 2'h0) else $error("gain zero");
  // Target registers in the same cycle as level, yet only settled values are held
  chk_target_formula: assert property (
    ($stable(rail_level_o) && $stable(rail_gain_o))[*2]
    |-> rail_target_o == tgt_calc) else $error("target formula");
  chk_den_range: assert property (
    outboard_ratio_den_o >= 7'h30 && outboard_ratio_den_o <= 7'h70)
    else $error("ratio denominator out of range");
  cover property (rail_low_power_o);
  cover property (ramp_busy_o ##1 !ramp_busy_o);
  cover property (outboard_enable_o);
  cover property (scl_rvalid_o);
endmodule
`default_nettype wire

//--- sim/crv_host_model.sv
// Host model driving the control and scaling register ports
`timescale 1ns/1ps
`default_nettype none
module crv_host_model (
  input  wire logic            clk_i,
  output var  logic            choice_o,
  output var  logic [1:0][7:0] addr_o,
  output var  logic [1:0][7:0] wdata_o,
  output var  logic [1:0]      wr_o,
  output var  logic [1:0]      rd_o
);
  logic [7:0] exp_q[2][$];
  initial begin
    choice_o = 1'b0;
    addr_o = '0;
    wdata_o = '0;
    wr_o = 2'h0;
    rd_o = 2'h0;
  end
  // ==========================================================
  // Owner of the paired registers follows this level
  task automatic set_choice(input logic c);
    @(posedge clk_i);
    choice_o <= c;
  endtask
  // One strobe per access, sometimes after an idle gap
  task automatic acc(input int p, input logic [7:0] a, input logic [7:0] d,
                     input logic w);
    repeat ($urandom_range(1, 0)) @(posedge clk_i);
    @(posedge clk_i);
    addr_o[p] <= a;
    wdata_o[p] <= d;
    if (w) begin
      wr_o[p] <= 1'b1;
    end else begin
      rd_o[p] <= 1'b1;
      exp_q[p].push_back(d);
    end
    @(posedge clk_i);
    wr_o[p] <= 1'b0;
    rd_o[p] <= 1'b0;
    // Released lines carry junk so a late sample is caught
    addr_o[p] <= ~a;
    wdata_o[p] <= ~d;
  endtask
endmodule
`default_nettype wire

//--- sim/test_crv_rail_regs.sv
// Self-checking bench for the rail register bank
`timescale 1ns/1ps
`default_nettype none
module test_crv_rail_regs;
  logic            clk_i = 1'b0;
  logic            reset_i = 1'b1;
  logic            choice;
  logic [1:0][7:0] h_addr;
  logic [1:0][7:0] h_wdata;
  logic [1:0]      h_wr;
  logic [1:0]      h_rd;
  logic [7:0]      c_rdata;
  logic [7:0]      s_rdata;
  logic            c_rv;
  logic            s_rv;
  logic            on;
  logic            lp;
  logic            ceil;
  logic            busy;
  logic            ob_en;
  logic [6:0]      lvl;
  logic [6:0]      den;
  logic [6:0]      l0;
  logic [9:0]      tgt;
  logic [1:0]      gain;
  logic [7:0]      v[6];
  logic [7:0]      rv[6] = '{8'h0c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
  logic [6:0]      lt[8] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h4b,
                             7'h4c, 7'h7f};
  logic [6:0]      ot[8] = '{7'h00, 7'h01, 7'h03, 7'h04, 7'h42, 7'h43,
                             7'h44, 7'h7f};
  int              nn[8] = '{0, 3, 4, 5, 6, 9, 12, 15};
  int              fail_count = 0;
  int              n_tests = 0;
  int              cyc = 0;
  int              n;
  wire logic [29:0] got_w = {on, lp, lvl, tgt, gain, ceil, ob_en, den};

  always #2 clk_i = ~clk_i;

  crv_host_model host_u (.clk_i(clk_i), .choice_o(choice), .addr_o(h_addr),
    .wdata_o(h_wdata), .wr_o(h_wr), .rd_o(h_rd));

  crv_rail_regs dut_u (.clk_i(clk_i), .reset_i(reset_i),
    .scaling_port_choice_i(choice), .ctl_addr_i(h_addr[0]),
    .ctl_wdata_i(h_wdata[0]), .ctl_wr_i(h_wr[0]), .ctl_rd_i(h_rd[0]),
    .ctl_rdata_o(c_rdata), .ctl_rvalid_o(c_rv), .scl_addr_i(h_addr[1]),
    .scl_wdata_i(h_wdata[1]), .scl_wr_i(h_wr[1]), .scl_rd_i(h_rd[1]),
    .scl_rdata_o(s_rdata), .scl_rvalid_o(s_rv), .rail_on_o(on),
    .rail_low_power_o(lp), .rail_level_o(lvl), .rail_target_o(tgt),
    .rail_gain_o(gain), .current_ceiling_o(ceil), .ramp_busy_o(busy),
    .outboard_enable_o(ob_en), .outboard_ratio_den_o(den));

  // ==========================================================
  // Checking
  task automatic bump(input logic [29:0] g, input logic [29:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_val(input logic [29:0] g, input logic [29:0] e);
    bump(g, e);
  endtask
  task automatic cmp_rd(input int p, input logic [7:0] g);
    logic [7:0] e;
    e = host_u.exp_q[p].size() ? host_u.exp_q[p].pop_front() : 8'hxx;
    bump({22'h0, g}, {22'h0, e});
  endtask
  function automatic logic [29:0] exp_all(input logic [7:0] c, op, sr, x,
                                          xo, xs);
    logic [6:0] k;
    logic [6:0] l;
    logic [6:0] r;
    logic [1:0] m;
    k = op[7] ? sr[6:0] : op[6:0];
    l = (k == 7'h00) ? 7'h00 : (k < 7'h03) ? 7'h03 : (k > 7'h4b) ? 7'h4b : k;
    m = c[7] ? c[7:6] : 2'h1;
    r = xo[7] ? xs[6:0] : xo[6:0];
    r = (r < 7'h03) ? 7'h03 : (r > 7'h43) ? 7'h43 : r;
    exp_all[29] = c[0] && l != 7'h00;
    exp_all[28] = c[0] && c[1] && l != 7'h00;
    exp_all[27:21] = l;
    exp_all[20:11] = (l == 7'h00) ? 10'h000 : (10'(l) * 2 + 10'h05a) * m;
    exp_all[10:9] = m;
    exp_all[8] = c[5];
    exp_all[7] = x[0] && (xo[7] ? xs[6:0] : xo[6:0]) != 7'h00;
    exp_all[6:0] = 7'h2d + r;
  endfunction
  task automatic wait_step(output int cnt);
    logic [6:0] s;
    s = lvl;
    cnt = 0;
    do begin
      @(posedge clk_i);
      cnt++;
    end while (lvl === s && cnt < 3000);
  endtask
  task automatic chk_reset;
    foreach (rv[i]) host_u.acc(0, 8'h24 + i, rv[i], 1'b0);
    host_u.acc(0, 8'h2a, 8'h00, 1'b0);
    repeat (4) @(posedge clk_i);
    cmp_val(got_w, exp_all(8'h0c, 0, 0, 0, 0, 8'h03));
  endtask
  task automatic test_done;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    if (c_rv === 1'b1) cmp_rd(0, c_rdata);
    if (s_rv === 1'b1) cmp_rd(1, s_rdata);
    cyc++;
    // Ramp sweep needs about 5000 cycles, the rest far fewer
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'h3da80267));
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    chk_reset();
    for (int i = 0; i < 3; i++) begin
      host_u.acc(0, 8'h26 + i + i / 2, 8'hff, 1'b1);
      host_u.acc(0, 8'h26 + i + i / 2, i == 1 ? 8'h03 : 8'h7f, 1'b0);
    end
    host_u.acc(1, 8'h25, 8'h55, 1'b1);
    host_u.acc(0, 8'h25, 8'h00, 1'b0);
    host_u.acc(1, 8'h25, 8'h00, 1'b0);
    host_u.set_choice(1'b1);
    host_u.acc(1, 8'h25, 8'h55, 1'b1);
    host_u.acc(0, 8'h25, 8'h11, 1'b1);
    host_u.acc(1, 8'h25, 8'h55, 1'b0);
    host_u.acc(0, 8'h25, 8'h00, 1'b0);
    host_u.acc(1, 8'h24, 8'h00, 1'b0);
    host_u.set_choice(1'b0);
    for (int i = 0; i < 16; i++) begin
      v[0] = {i[1:0], 1'($urandom), 3'h0, i[3:2]};
      v[1] = {i[0], lt[i % 8]};
      v[2] = {1'($urandom), i < 8 ? lt[(i + 3) % 8] : 7'($urandom)};
      v[3] = {6'($urandom), i[3:2]};
      v[4] = {i[1], ot[i % 8]};
      v[5] = {1'($urandom), ot[(i + 5) % 8]};
      foreach (v[j]) host_u.acc(0, 8'h24 + j, v[j], 1'b1);
      repeat (4) @(posedge clk_i);
      cmp_val(got_w, exp_all(v[0], v[1], v[2], v[3], v[4], v[5]));
    end
    host_u.acc(0, 8'h24, 8'h01, 1'b1);
    host_u.acc(0, 8'h25, 8'h03, 1'b1);
    for (int k = 1; k < 8; k++) begin
      host_u.acc(0, 8'h24, {3'h0, 3'(k), 2'h1}, 1'b1);
      host_u.acc(0, 8'h25, {1'b0, 7'(3 * k + 3)}, 1'b1);
      wait_step(n);
      for (int s = 0; s < 2; s++) begin
        l0 = 7'(3 * k + 1 + s);
        wait_step(n);
        cmp_val(30'(lvl), 30'(l0 + 7'h01));
        cmp_val(30'(9 * n > 250 * nn[k] - 19 && 9 * n < 250 * nn[k] + 19),
                30'h1);
      end
      repeat (3) @(posedge clk_i);
      cmp_val(30'(busy), 30'h0);
    end
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    chk_reset();
    test_done();
  end
endmodule

bind crv_rail_regs crv_rail_props chk_u (.clk_i(clk_i), .reset_i(reset_i),
  .ctl_rd_i(ctl_rd_i), .ctl_addr_i(ctl_addr_i), .ctl_rdata_o(ctl_rdata_o),
  .ctl_rvalid_o(ctl_rvalid_o), .scl_rd_i(scl_rd_i), .scl_addr_i(scl_addr_i),
  .scl_rdata_o(scl_rdata_o), .scl_rvalid_o(scl_rvalid_o),
  .rail_on_o(rail_on_o), .rail_low_power_o(rail_low_power_o),
  .rail_level_o(rail_level_o), .rail_target_o(rail_target_o),
  .rail_gain_o(rail_gain_o), .ramp_busy_o(ramp_busy_o),
  .outboard_enable_o(outboard_enable_o),
  .outboard_ratio_den_o(outboard_ratio_den_o));
`default_nettype wire
